// ### fspc_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - processor stalls from start until the operation finishes.
// - operation length is a count of internal oscillator cycles.
// - start bit 15 launches the operation; hardware clears it at end.
// - erase-select bit 6 chooses erase or program decoding.
// - erase codes: F bulk, D segment, 2 page, 0 config byte.
// - program codes: 3 word, 1 row, 0 config byte; others decode to no kind but still launch and stall.
// - no operation proceeds without the key sequence just before.
// - key register is write-only, reads return zero.
// - pages and rows are aligned at 1536 and 192 byte boundaries; flash_addr is passed on unaligned.
// - 64 holding buffers; table writes update these buffers, load the target address and cancel a pending key sequence.
// - target address is page pointer bits 7:0 with working address.
module fspc_ctrl #(
  parameter int ROW_WORDS = fspc_pkg::FSPC_ROW_WORDS,
  parameter int RC_CYCLES = fspc_pkg::FSPC_RC_CYCLES_ROW
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic tbl_wr_low,
  input wire logic tbl_wr_high,
  input wire logic [7:0] table_page_pointer,
  input wire logic [15:0] tbl_ea,
  input wire logic [15:0] tbl_wdata,
  output logic cpu_stall,
  output logic flash_go,
  output logic [3:0] flash_kind,
  output logic [3:0] flash_op,
  output logic [23:0] flash_addr,
  input wire logic [5:0] buf_idx,
  output logic [23:0] buf_word
);
  typedef enum logic [2:0] {
    FSPC_ST_IDLE = 3'b001,
    FSPC_ST_KEY1 = 3'b010,
    FSPC_ST_ARMED = 3'b100
  } fspc_key_t;

  fspc_key_t key_q, key_d;
  logic [15:0] ctl_q, ctl_d;
  logic [23:0] addr_q, addr_d;
  logic go_q, go_d;
  logic [23:0] hold_q [ROW_WORDS];
  logic wr_ctl, wr_key, set_start;
  logic [3:0] op;
  fspc_pkg::fspc_kind_t kind;
  fspc_timer_if tif();

  // map the erase flag and code to an operation kind
  function automatic fspc_pkg::fspc_kind_t decode(input logic erase,
                                                  input logic [3:0] code);
    fspc_pkg::fspc_kind_t k;
    k = fspc_pkg::FSPC_KIND_NONE;
    if (erase) begin
      case (code)
        fspc_pkg::FSPC_OP_BULK, fspc_pkg::FSPC_OP_SEGMENT,
        fspc_pkg::FSPC_OP_PAGE: k = fspc_pkg::FSPC_KIND_ERASE;
        fspc_pkg::FSPC_OP_CONFIG: k = fspc_pkg::FSPC_KIND_CFG;
        default: k = fspc_pkg::FSPC_KIND_NONE;
      endcase
    end else begin
      case (code)
        fspc_pkg::FSPC_OP_WORD,
        fspc_pkg::FSPC_OP_ROW: k = fspc_pkg::FSPC_KIND_PROG;
        fspc_pkg::FSPC_OP_CONFIG: k = fspc_pkg::FSPC_KIND_CFG;
        default: k = fspc_pkg::FSPC_KIND_NONE;
      endcase
    end
    return k;
  endfunction

  assign wr_ctl = reg_wr && reg_addr == fspc_pkg::FSPC_OFS_CONTROL;
  assign wr_key = reg_wr && reg_addr == fspc_pkg::FSPC_OFS_KEY;
  assign set_start = wr_ctl && reg_wdata[fspc_pkg::FSPC_START_BIT]
                     && !ctl_q[fspc_pkg::FSPC_START_BIT];
  assign op = ctl_q[fspc_pkg::FSPC_OP_LSB +: fspc_pkg::FSPC_OP_W];
  assign kind = decode(ctl_q[fspc_pkg::FSPC_ERASE_BIT], op);

  always_comb begin
    key_d = key_q;
    ctl_d = ctl_q;
    addr_d = addr_q;
    go_d = 1'b0;
    case (key_q)
      FSPC_ST_IDLE: if (wr_key && reg_wdata[7:0] == fspc_pkg::FSPC_KEY_FIRST)
        key_d = FSPC_ST_KEY1;
      FSPC_ST_KEY1: begin
        if (wr_key && reg_wdata[7:0] == fspc_pkg::FSPC_KEY_SECOND)
          key_d = FSPC_ST_ARMED;
        else if (reg_wr || tbl_wr_low || tbl_wr_high)
          key_d = FSPC_ST_IDLE;
      end
      FSPC_ST_ARMED: if (reg_wr || tbl_wr_low || tbl_wr_high)
        key_d = FSPC_ST_IDLE;
      default: key_d = FSPC_ST_IDLE;
    endcase
    if (wr_ctl && !ctl_q[fspc_pkg::FSPC_START_BIT]) begin
      // start is set-only; fault is hardware-owned
      ctl_d = (reg_wdata & fspc_pkg::FSPC_CONTROL_WMASK)
              | (ctl_q & ~fspc_pkg::FSPC_CONTROL_WMASK);
    end
    if (set_start) begin
      if (key_q == FSPC_ST_ARMED && reg_wdata[fspc_pkg::FSPC_ALLOW_BIT])
      begin
        ctl_d[fspc_pkg::FSPC_START_BIT] = 1'b1;
        go_d = 1'b1;
      end else begin
        ctl_d[fspc_pkg::FSPC_FAULT_BIT] = 1'b1;
      end
    end
    if (tif.done) begin
      ctl_d[fspc_pkg::FSPC_START_BIT] = 1'b0;
      ctl_d[fspc_pkg::FSPC_FAULT_BIT] = 1'b0;
    end
    if (tbl_wr_low || tbl_wr_high)
      addr_d = {table_page_pointer, tbl_ea};
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_q <= FSPC_ST_IDLE;
      ctl_q <= fspc_pkg::FSPC_CONTROL_RESET;
      addr_q <= 24'h000000;
      go_q <= 1'b0;
    end else begin
      key_q <= key_d;
      ctl_q <= ctl_d;
      addr_q <= addr_d;
      go_q <= go_d;
    end
  end

  // holding buffers: table writes fill these and also load the target address, never the array
  always_ff @(posedge core_clk) begin
    if (tbl_wr_low)
      hold_q[tbl_ea[6:1]][15:0] <= tbl_wdata;
    if (tbl_wr_high)
      hold_q[tbl_ea[6:1]][23:16] <= tbl_wdata[7:0];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      buf_word <= 24'h000000;
    else
      buf_word <= hold_q[buf_idx];
  end

  assign tif.start = go_q;
  assign tif.cycles = 16'(RC_CYCLES);

  fspc_rc_timer u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tif(tif)
  );

  // key register reads as zero
  assign reg_rdata = (reg_rd && reg_addr == fspc_pkg::FSPC_OFS_CONTROL)
                     ? ctl_q : 16'h0000;
  assign cpu_stall = ctl_q[fspc_pkg::FSPC_START_BIT];
  assign flash_go = go_q;
  assign flash_kind = kind;
  assign flash_op = op;
  // full table address passed unaligned for every op; row and page alignment left to the array
  assign flash_addr = addr_q;

  stall_while_busy_a: assert property (@(posedge core_clk) disable iff
    (!arst_n) tif.busy |-> cpu_stall) else $error("busy without stall");
  start_launch_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    go_q |-> ##1 tif.busy) else $error("start did not launch timer");
  clear_on_done_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    tif.done |=> !cpu_stall) else $error("start not cleared at end");
  allow_needed_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    go_q |-> ctl_q[fspc_pkg::FSPC_ALLOW_BIT])
    else $error("ran without write enable");
  key_needed_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    go_q |-> $past(key_q) == FSPC_ST_ARMED)
    else $error("ran without unlock");
  fault_on_bad_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    set_start && key_q != FSPC_ST_ARMED |=> ctl_q[fspc_pkg::FSPC_FAULT_BIT])
    else $error("fault not flagged");
  no_sw_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    cpu_stall && !tif.done |=> cpu_stall)
    else $error("start cleared early");
  key_reads_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_addr == fspc_pkg::FSPC_OFS_KEY |-> reg_rdata == 16'h0000)
    else $error("key readable");
  cover_row_prog: cover property (@(posedge core_clk)
    go_q && kind == fspc_pkg::FSPC_KIND_PROG);
  cover_erase: cover property (@(posedge core_clk)
    go_q && kind == fspc_pkg::FSPC_KIND_ERASE);
  cover_fault: cover property (@(posedge core_clk)
    $rose(ctl_q[fspc_pkg::FSPC_FAULT_BIT]));
endmodule // fspc_ctrl

// ### fspc_pkg.sv
package fspc_pkg;
  // special function register offsets inside the processor's register window
  localparam logic [3:0] FSPC_OFS_CONTROL = 4'h0;
  localparam logic [3:0] FSPC_OFS_KEY = 4'h1;
  localparam int FSPC_REG_W = 16;
  // control register fields
  localparam int FSPC_START_BIT = 15;
  localparam int FSPC_ALLOW_BIT = 14;
  localparam int FSPC_FAULT_BIT = 13;
  localparam int FSPC_ERASE_BIT = 6;
  localparam int FSPC_OP_LSB = 0;
  localparam int FSPC_OP_W = 4;
  localparam logic [15:0] FSPC_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] FSPC_CONTROL_WMASK = 16'h404F;
  localparam logic [7:0] FSPC_KEY_FIRST = 8'h55;
  localparam logic [7:0] FSPC_KEY_SECOND = 8'hAA;
  // operation codes
  localparam logic [3:0] FSPC_OP_BULK = 4'hF;
  localparam logic [3:0] FSPC_OP_SEGMENT = 4'hD;
  localparam logic [3:0] FSPC_OP_WORD = 4'h3;
  localparam logic [3:0] FSPC_OP_PAGE = 4'h2;
  localparam logic [3:0] FSPC_OP_ROW = 4'h1;
  localparam logic [3:0] FSPC_OP_CONFIG = 4'h0;
  // geometry
  localparam int FSPC_ROW_WORDS = 64;
  localparam int FSPC_PAGE_BYTES = 1536;
  localparam int FSPC_ROW_BYTES = 192;
  localparam int FSPC_ADDR_W = 24;
  // timing: operation lengths in internal oscillator cycles
  localparam real FSPC_RC_MHZ = 7.37;
  localparam real FSPC_CLK_MHZ = 200.0;
  localparam int FSPC_RC_CYCLES_ROW = 11064;
  // one rc tick every N core cycles, rounded down
  localparam int FSPC_RC_DIV = int'(FSPC_CLK_MHZ / FSPC_RC_MHZ - 0.5);
  typedef enum logic [3:0] {
    FSPC_KIND_NONE = 4'h1,
    FSPC_KIND_ERASE = 4'h2,
    FSPC_KIND_PROG = 4'h4,
    FSPC_KIND_CFG = 4'h8
  } fspc_kind_t;
endpackage

// ### fspc_timer_if.sv
`timescale 1ns/1ps
interface fspc_timer_if;
  logic start;
  logic [15:0] cycles;
  logic busy;
  logic done;
  modport ctrl (output start, output cycles, input busy, input done);
  modport tmr (input start, input cycles, output busy, output done);
endinterface

// ### fspc_rc_timer.sv
`timescale 1ns/1ps
module fspc_rc_timer #(
  parameter int DIV = fspc_pkg::FSPC_RC_DIV
) (
  input wire logic core_clk,
  input wire logic arst_n,
  fspc_timer_if.tmr tif
);
  logic [7:0] div_q, div_d;
  logic [15:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic tick;

  // the rc tick is a one-cycle enable, counted only while busy
  assign tick = busy_q && (div_q == 8'(DIV - 1));

  always_comb begin
    div_d = div_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (tif.start && !busy_q) begin
      busy_d = 1'b1;
      div_d = 8'h00;
      cnt_d = tif.cycles;
    end else if (busy_q) begin
      div_d = tick ? 8'h00 : div_q + 8'h01;
      if (tick) begin
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q <= 16'h0001) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 8'h00;
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign tif.busy = busy_q;
  assign tif.done = done_q;

  busy_ends_done_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(busy_q) |-> done_q) else $error("timer ended without done");
endmodule // fspc_rc_timer

// ### tb_flash_self_program_control.sv
`timescale 1ns/1ps
module tb_flash_self_program_control;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tbl_wr_low = 1'b0, tbl_wr_high = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, tbl_ea = 16'h0000, tbl_wdata = 16'h0000;
  logic [7:0] table_page_pointer = 8'h00;
  logic [5:0] buf_idx = 6'h00;
  logic [15:0] reg_rdata;
  logic cpu_stall, flash_go;
  logic [3:0] flash_kind, flash_op;
  logic [23:0] flash_addr, buf_word;
  int miscompares = 0;
  int checked = 0;
  logic [15:0] v;

  always #2.5 core_clk = ~core_clk;

  // short op length keeps each run near a hundred core cycles
  fspc_ctrl #(.RC_CYCLES(4)) fspc_ctrl_inst (
    .core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tbl_wr_low(tbl_wr_low), .tbl_wr_high(tbl_wr_high),
    .table_page_pointer(table_page_pointer), .tbl_ea(tbl_ea),
    .tbl_wdata(tbl_wdata), .cpu_stall(cpu_stall), .flash_go(flash_go),
    .flash_kind(flash_kind), .flash_op(flash_op), .flash_addr(flash_addr),
    .buf_idx(buf_idx), .buf_word(buf_word));

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    #1 d = reg_rdata;
  endtask

  // back to back, nothing between them
  task automatic keys;
    wr(fspc_pkg::FSPC_OFS_KEY, 16'h0055);
    wr(fspc_pkg::FSPC_OFS_KEY, 16'h00AA);
  endtask

  function automatic logic [3:0] kind_of(input logic [15:0] c);
    if (c[3:0] == 4'h0) return fspc_pkg::FSPC_KIND_CFG;
    if (c[6]) return (c[3:0] == 4'hF || c[3:0] == 4'hD || c[3:0] == 4'h2) ?
      fspc_pkg::FSPC_KIND_ERASE : fspc_pkg::FSPC_KIND_NONE;
    return (c[3:0] == 4'h3 || c[3:0] == 4'h1) ?
      fspc_pkg::FSPC_KIND_PROG : fspc_pkg::FSPC_KIND_NONE;
  endfunction

  task automatic fail_start(input logic [15:0] c);
    bit go;
    go = 1'b0;
    wr(fspc_pkg::FSPC_OFS_CONTROL, c);
    repeat (4) begin
      @(posedge core_clk);
      #1 if (flash_go !== 1'b0 || cpu_stall !== 1'b0) go = 1'b1;
    end
    cmp(go, 1'b0, "refused start ran");
    rd(fspc_pkg::FSPC_OFS_CONTROL, v);
    cmp(v[15:13], {1'b0, c[14], 1'b1}, "fault after refused start");
  endtask

  task automatic run_op(input logic [15:0] s);
    bit go;
    go = 1'b0;
    wr(fspc_pkg::FSPC_OFS_CONTROL, s);
    #1 cmp(flash_kind, kind_of(s), "kind decode");
    if (kind_of(s) != fspc_pkg::FSPC_KIND_NONE) begin
      keys();
      wr(fspc_pkg::FSPC_OFS_CONTROL, s | 16'h8000);
      // the launch pulse stands only in the cycle after the start write
      #1 go = (flash_go === 1'b1);
      cmp(go, 1'b1, "no launch");
      cmp(cpu_stall, 1'b1, "stall at launch");
      cmp(flash_op, s[3:0], "op code");
      wr(fspc_pkg::FSPC_OFS_CONTROL, 16'h0000);
      rd(fspc_pkg::FSPC_OFS_CONTROL, v);
      cmp(v[15], 1'b1, "start cleared by write");
      cmp(cpu_stall, 1'b1, "stall ended early");
      for (int n = 0; n < 400 && cpu_stall !== 1'b0; n++)
        @(posedge core_clk);
      #1 cmp(cpu_stall, 1'b0, "stall never ends");
      rd(fspc_pkg::FSPC_OFS_CONTROL, v);
      cmp(v, s, "control after run");
    end
  endtask

  task automatic tw(input bit hi, input logic [15:0] d);
    @(posedge core_clk);
    tbl_wr_low <= !hi;
    tbl_wr_high <= hi;
    tbl_wdata <= d;
    @(posedge core_clk);
    tbl_wr_low <= 1'b0;
    tbl_wr_high <= 1'b0;
  endtask

  initial begin
    #200000;
    miscompares++;
    results();
  end

  initial begin
    logic [15:0] lo, hb;
    logic [5:0] ix;
    void'($urandom(68403));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(fspc_pkg::FSPC_OFS_CONTROL, v);
    cmp(v, fspc_pkg::FSPC_CONTROL_RESET, "control reset");
    cmp(flash_kind, kind_of(fspc_pkg::FSPC_CONTROL_RESET), "kind reset");
    wr(fspc_pkg::FSPC_OFS_KEY, 16'h0055);
    rd(fspc_pkg::FSPC_OFS_KEY, v);
    cmp(v, 16'h0000, "key readable");
    fail_start(16'hC001);
    keys();
    fail_start(16'h8001);
    wr(fspc_pkg::FSPC_OFS_KEY, 16'h0055);
    wr(fspc_pkg::FSPC_OFS_CONTROL, 16'h4001);
    wr(fspc_pkg::FSPC_OFS_KEY, 16'h00AA);
    fail_start(16'hC001);
    // page erases come after row programs here; order is software's
    for (int e = 0; e < 2; e++) begin
      for (int k = 0; k < 6; k++) begin
        lo = {12'h400, 4'(k == 0 ? 15 : k == 1 ? 13 : 5 - k)};
        run_op(lo | 16'(e << 6));
      end
    end
    repeat (4) begin
      ix = 6'($urandom);
      lo = 16'($urandom);
      hb = 16'($urandom);
      table_page_pointer <= 8'($urandom);
      tbl_ea <= {9'($urandom), ix, 1'b0};
      tw(1'b0, lo);
      tw(1'b1, hb);
      buf_idx <= ix;
      @(posedge core_clk);
      #1 cmp(buf_word, {hb[7:0], lo}, "holding buffer");
      cmp(flash_addr, {table_page_pointer, tbl_ea}, "target addr");
    end
    keys();
    tw(1'b0, 16'h1234);
    fail_start(16'hC001);
    results();
  end
endmodule // tb_flash_self_program_control
